// *** asrc_out_defines.svh ***
`ifndef ASRC_OUT_DEFINES_SVH
`define ASRC_OUT_DEFINES_SVH

// Register offsets
`define REG_SYS_CTRL    7'h01
`define REG_FORMAT      7'h03
`define REG_ATTEN_L     7'h04
`define REG_ATTEN_R     7'h05
`define REG_RATIO_HI    7'h06
`define REG_RATIO_LO    7'h07

// Field positions, write masks and the value read from unmapped addresses
`define TRACK_BIT       6
`define MODE_MSB        2
`define MODE_LSB        0
`define OWL_MSB         7
`define OWL_LSB         6
`define OFMT_MSB        5
`define OFMT_LSB        4
`define SYS_CTRL_MASK   8'hdf
`define FORMAT_MASK     8'hf7
`define READ_ZERO       8'h00

// Port mode codes
`define MODE_MASTER_128 3'h1
`define MODE_MASTER_512 3'h2
`define MODE_MASTER_256 3'h3

// Frame geometry in bit clocks
`define WORD_BITS       24
`define SLOT_BITS       6'h20
`define SUBFRAME_LEN    10'h040
`define FRAME_LEN_128   10'h080
`define FRAME_LEN_256   10'h100
`define FRAME_LEN_512   10'h200

// Reference edges per half bit clock when not in TDM
`define HALF_DIV_128    3'h1
`define HALF_DIV_256    3'h2
`define HALF_DIV_512    3'h4

// Serial control frame
`define SPI_CMD_LAST    4'h7
`define SPI_FRAME_LAST  4'hf
`define SPI_READ_BIT    7

// Attenuation arithmetic
`define GAIN_FRAC       16
`define STEPS_PER_6DB   8'h0c

`endif

// *** asrc_out_pkg.sv ***
package asrc_out_pkg;

  typedef enum logic [1:0] {
    FMT_LEFT  = 2'b00,
    FMT_I2S   = 2'b01,
    FMT_TDM   = 2'b10,
    FMT_RIGHT = 2'b11
  } out_format_t;

  typedef enum logic [1:0] {
    WL_24 = 2'b00,
    WL_20 = 2'b01,
    WL_18 = 2'b10,
    WL_16 = 2'b11
  } word_length_t;

  typedef enum logic [1:0] {
    SPI_IDLE = 2'b00,
    SPI_CMD  = 2'b01,
    SPI_DATA = 2'b10,
    SPI_DONE = 2'b11
  } spi_phase_t;

  typedef struct packed {
    logic [23:0] left;
    logic [23:0] right;
  } audio_pair_t;

  typedef struct packed {
    logic [4:0]  integer_part;
    logic [10:0] fraction_part;
  } ratio_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic mosi;
  } spi_pins_t;

  typedef struct packed {
    logic [7:0]  sys_ctrl;
    logic [7:0]  format;
    logic [7:0]  atten_l;
    logic [7:0]  atten_r;
    ratio_t      ratio_snap;
    spi_phase_t  phase;
    logic [3:0]  spi_count;
    logic [7:0]  spi_shift_in;
    logic [7:0]  spi_shift_out;
    logic [6:0]  spi_addr;
    logic        spi_read;
    logic        sclk_last;
    logic        miso;
    logic        ref_last;
    logic [2:0]  div_cnt;
    logic        bclk_gen;
    logic        bclk_last;
    logic        frame_last;
    logic        frame_gen;
    logic [9:0]  pos;
    audio_pair_t pending;
    audio_pair_t frame_word;
    logic        data_bit;
    logic        data_en;
  } state_t;

endpackage

// *** sync_stage.sv ***
`timescale 1ns/10ps
module sync_stage #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// *** asrc_output_port.sv ***
`timescale 1ns/10ps
`include "asrc_out_defines.svh"
// Contract
// (RL1) Format field: 00 left-justified, 01 I2S, 10 TDM, 11 right-justified.
// (RL2) Word length field: 00 24 bits, 01 20, 10 18, 11 16 bits.
// (RL3) Left output attenuated by left register times 0.5 dB, reset zero.
// (RL4) Right output attenuated by right register times 0.5 dB, reset zero.
// (RL5) Tracking bit set: left attenuation also used for right channel.
// (RL6) Upper ratio register bits 7..3 hold the ratio integer part.
// (RL7) Fraction: top three bits in upper 2..0, low eight in lower.
// (RL8) Reading the upper ratio register refreshes both ratio registers together.
// (RL9) Host reads upper ratio register before the lower one.
// (RL10) Ratio registers are read-only; writes do nothing.
// (RL11) TDM: each section one sub-frame, left channel then right.
// (RL12) TDM sub-frame is 64 bit clocks, 32 per channel.
// (RL13) Audio data left-justified in each 32-bit slot.
// (RL14) Frame repeats once per sample; bit clock is N times 64 fs.
// (RL15) Master TDM: bit clock equals reference clock frequency.
// (RL16) Sections equal bit clock over frame rate over 64.
// (RL17) Slave transmitter should use this section's reference as master clock.
// (RL18) Mode 001, 010, 011: output master at 128, 512, 256 fs.
// (RL19) Word length in format bits 7..6, format in 5..4, reset zero.
// (RL20) TDM: section drives data only inside its own sub-frame.
module asrc_output_port
  import asrc_out_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire spi_pins_t   spi_in,
  output logic             spi_miso,
  output logic             spi_miso_oe,
  input  wire logic        reference_clock_input,
  input  wire logic        output_bit_clock_in,
  output logic             output_bit_clock_out,
  output logic             output_bit_clock_oe,
  input  wire logic        output_frame_clock_in,
  output logic             output_frame_clock_out,
  output logic             output_frame_clock_oe,
  output logic             serial_data_out,
  output logic             serial_data_oe,
  input  wire audio_pair_t sample_in,
  input  wire logic        sample_strobe,
  input  wire ratio_t      ratio_in,
  input  wire logic [1:0]  tdm_section_index
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [23:0] attenuate(input logic [23:0] smp,
                                            input logic [7:0]  steps);
    logic [16:0]        gain;
    logic [7:0]         rem;
    logic [7:0]         shift;
    logic signed [41:0] prod;
    rem   = steps % `STEPS_PER_6DB;
    shift = steps / `STEPS_PER_6DB;
    unique case (rem)
      8'h00:   gain = 17'h10000;
      8'h01:   gain = 17'h0f1ae;
      8'h02:   gain = 17'h0e429;
      8'h03:   gain = 17'h0d766;
      8'h04:   gain = 17'h0cb59;
      8'h05:   gain = 17'h0bff9;
      8'h06:   gain = 17'h0b53c;
      8'h07:   gain = 17'h0ab19;
      8'h08:   gain = 17'h0a186;
      8'h09:   gain = 17'h0987d;
      8'h0a:   gain = 17'h08ff6;
      default: gain = 17'h087e8;
    endcase
    prod = $signed(smp) * $signed({1'b0, gain});
    prod = prod >>> `GAIN_FRAC;
    prod = prod >>> shift;
    return prod[23:0];
  endfunction

  function automatic logic [5:0] word_bits(input word_length_t len);
    unique case (len)
      WL_24: return 6'h18;
      WL_20: return 6'h14;
      WL_18: return 6'h12;
      WL_16: return 6'h10;
    endcase
  endfunction

  function automatic logic serial_bit(input logic [23:0]  word,
                                      input out_format_t  fmt_i,
                                      input word_length_t len,
                                      input logic [4:0]   slot_pos);
    logic [5:0] nbits;
    logic [5:0] offset;
    logic [5:0] k;
    nbits  = word_bits(len);
    offset = 6'h00;
    if (fmt_i == FMT_I2S) begin
      offset = 6'h01;
    end else if (fmt_i == FMT_RIGHT) begin
      offset = `SLOT_BITS - nbits;
    end
    k = {1'b0, slot_pos} - offset;
    if ({1'b0, slot_pos} >= offset && k < nbits) begin
      return word[5'(`WORD_BITS - 1 - int'(k))];
    end
    return 1'b0;
  endfunction

  function automatic logic [7:0] read_value(input state_t     st,
                                            input logic [6:0] addr);
    unique case (addr)
      `REG_SYS_CTRL: return st.sys_ctrl;
      `REG_FORMAT:   return st.format;
      `REG_ATTEN_L:  return st.atten_l;
      `REG_ATTEN_R:  return st.atten_r;
      `REG_RATIO_LO: return st.ratio_snap.fraction_part[7:0];
      default:       return `READ_ZERO;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  state_t     s_q;
  state_t     s_d;
  logic [5:0] pin_sync;

  sync_stage #(
    .WIDTH(6)
  ) u_sync (
    .clk      (ref_clk),
    .rst      (rst),
    .async_in ({spi_in.cs_n, spi_in.sclk, spi_in.mosi, reference_clock_input,
                output_bit_clock_in, output_frame_clock_in}),
    .sync_out (pin_sync)
  );

  logic cs_n_s;
  logic sclk_s;
  logic mosi_s;
  logic ref_s;
  logic bclk_in_s;
  logic frame_in_s;

  assign cs_n_s     = pin_sync[5];
  assign sclk_s     = pin_sync[4];
  assign mosi_s     = pin_sync[3];
  assign ref_s      = pin_sync[2];
  assign bclk_in_s  = pin_sync[1];
  assign frame_in_s = pin_sync[0];

  ////////////////////////////////////////////////////////////////////////////
  // Decoded controls

  out_format_t  fmt;
  word_length_t wlen;
  logic [2:0]   mode;
  logic         master;
  logic         tdm;
  logic [2:0]   half_div;
  logic [9:0]   frame_len;
  audio_pair_t  atten_pair;

  assign fmt    = out_format_t'(s_q.format[`OFMT_MSB:`OFMT_LSB]);      // RL1 RL19
  assign wlen   = word_length_t'(s_q.format[`OWL_MSB:`OWL_LSB]);       // RL2 RL19
  assign mode   = s_q.sys_ctrl[`MODE_MSB:`MODE_LSB];
  assign tdm    = (fmt == FMT_TDM);
  assign master = (mode == `MODE_MASTER_128) || (mode == `MODE_MASTER_512) ||
                  (mode == `MODE_MASTER_256);                           // RL18

  always_comb begin
    unique case (mode)
      `MODE_MASTER_512: begin
        half_div  = `HALF_DIV_512;
        frame_len = `FRAME_LEN_512;
      end
      `MODE_MASTER_256: begin
        half_div  = `HALF_DIV_256;
        frame_len = `FRAME_LEN_256;
      end
      default: begin
        half_div  = `HALF_DIV_128;
        frame_len = `FRAME_LEN_128;
      end
    endcase
    if (!tdm) begin
      frame_len = `SUBFRAME_LEN;
    end
  end

  assign atten_pair.left  = attenuate(sample_in.left, s_q.atten_l);      // RL3
  assign atten_pair.right = attenuate(sample_in.right,
                                      s_q.sys_ctrl[`TRACK_BIT] ? s_q.atten_l
                                                               : s_q.atten_r); // RL4 RL5

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection and frame position

  logic        sclk_rise;
  logic        sclk_fall;
  logic [7:0]  in_byte;
  logic        ref_rise;
  logic        bclk_now;
  logic        bclk_fall;
  logic        slave_start;
  logic [9:0]  pos_next;
  logic        own_sub;
  audio_pair_t word_now;
  logic        frame_level;

  assign sclk_rise = sclk_s & ~s_q.sclk_last;
  assign sclk_fall = ~sclk_s & s_q.sclk_last;
  assign in_byte   = {s_q.spi_shift_in[6:0], mosi_s};
  assign ref_rise  = ref_s & ~s_q.ref_last;
  assign bclk_now  = master ? s_q.bclk_gen : bclk_in_s;
  assign bclk_fall = s_q.bclk_last & ~bclk_now;

  assign slave_start = (frame_in_s != s_q.frame_last) &&
                       (frame_in_s == (fmt != FMT_I2S));

  always_comb begin
    if (master) begin
      pos_next = (s_q.pos == frame_len - 10'h001) ? '0 : s_q.pos + 10'h001; // RL14 RL16
    end else begin
      pos_next = slave_start ? '0 : s_q.pos + 10'h001;                       // RL14 RL16
    end
  end

  assign own_sub  = (pos_next[9:6] == {2'b00, tdm_section_index});          // RL11 RL20
  assign word_now = (pos_next == '0) ? s_q.pending : s_q.frame_word;

  always_comb begin
    unique case (fmt)
      FMT_TDM: frame_level = (pos_next == '0);
      FMT_I2S: frame_level = pos_next[5];
      default: frame_level = ~pos_next[5];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;
    s_d.sclk_last = sclk_s;
    s_d.ref_last  = ref_s;
    s_d.bclk_last = bclk_now;

    // Control port
    if (cs_n_s) begin
      s_d.phase     = SPI_IDLE;
      s_d.spi_count = '0;
    end else begin
      unique case (s_q.phase)
        SPI_IDLE: s_d.phase = SPI_CMD;
        SPI_CMD: begin
          if (sclk_rise) begin
            s_d.spi_shift_in = in_byte;
            s_d.spi_count    = s_q.spi_count + 4'h1;
            if (s_q.spi_count == `SPI_CMD_LAST) begin
              s_d.spi_addr      = in_byte[6:0];
              s_d.spi_read      = in_byte[`SPI_READ_BIT];
              s_d.phase         = SPI_DATA;
              s_d.spi_shift_out = read_value(s_q, in_byte[6:0]);
              if (in_byte[`SPI_READ_BIT] && in_byte[6:0] == `REG_RATIO_HI) begin
                s_d.ratio_snap    = ratio_in;                             // RL8
                s_d.spi_shift_out = {ratio_in.integer_part,
                                     ratio_in.fraction_part[10:8]};       // RL6 RL7
              end
            end
          end
        end
        SPI_DATA: begin
          if (sclk_fall) begin
            s_d.miso          = s_q.spi_shift_out[7];
            s_d.spi_shift_out = {s_q.spi_shift_out[6:0], 1'b0};
          end
          if (sclk_rise) begin
            s_d.spi_shift_in = in_byte;
            s_d.spi_count    = s_q.spi_count + 4'h1;
            if (s_q.spi_count == `SPI_FRAME_LAST) begin
              s_d.phase = SPI_DONE;
              if (!s_q.spi_read) begin
                unique case (s_q.spi_addr)
                  `REG_SYS_CTRL: s_d.sys_ctrl = in_byte & `SYS_CTRL_MASK;
                  `REG_FORMAT:   s_d.format   = in_byte & `FORMAT_MASK;   // RL19
                  `REG_ATTEN_L:  s_d.atten_l  = in_byte;                  // RL3
                  `REG_ATTEN_R:  s_d.atten_r  = in_byte;                  // RL4
                  default:       s_d.format   = s_q.format;               // RL10
                endcase
              end
            end
          end
        end
        SPI_DONE: s_d.phase = SPI_DONE;
      endcase
    end

    // Samples for the next frame
    if (sample_strobe) begin
      s_d.pending = atten_pair;                                           // RL3 RL4 RL5
    end

    // Master bit clock
    if (!master) begin
      s_d.bclk_gen = 1'b0;
      s_d.div_cnt  = '0;
    end else if (tdm) begin
      s_d.bclk_gen = ref_s;                                               // RL15
      s_d.div_cnt  = '0;
    end else if (ref_rise) begin
      if (s_q.div_cnt == half_div - 3'h1) begin
        s_d.div_cnt  = '0;
        s_d.bclk_gen = ~s_q.bclk_gen;                                     // RL18
      end else begin
        s_d.div_cnt = s_q.div_cnt + 3'h1;
      end
    end

    // Serial output, changes on bit clock falling edge
    if (bclk_fall) begin
      s_d.frame_last = frame_in_s;
      s_d.pos        = pos_next;
      s_d.frame_gen  = frame_level;                                       // RL1
      if (pos_next == '0) begin
        s_d.frame_word = s_q.pending;                                     // RL14
      end
      s_d.data_bit = serial_bit(pos_next[5] ? word_now.right : word_now.left,
                                fmt, wlen, pos_next[4:0]);                // RL2 RL12 RL13
      s_d.data_en  = !tdm || own_sub;                                     // RL20
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign spi_miso               = s_q.miso;
  assign spi_miso_oe            = ~cs_n_s;
  assign output_bit_clock_out   = s_q.bclk_gen;
  assign output_bit_clock_oe    = master;
  assign output_frame_clock_out = s_q.frame_gen;
  assign output_frame_clock_oe  = master;
  assign serial_data_out        = s_q.data_bit;
  assign serial_data_oe         = s_q.data_en;

endmodule

// *** asrc_output_port_assertions.sv ***
`timescale 1ns/10ps
module asrc_output_port_checker
  import asrc_out_pkg::*;
(
  input wire logic      ref_clk,
  input wire logic      rst,
  input wire spi_pins_t spi_in,
  input wire logic      spi_miso,
  input wire logic      spi_miso_oe,
  input wire logic      output_bit_clock_in,
  input wire logic      output_bit_clock_oe,
  input wire logic      output_frame_clock_oe,
  input wire logic      serial_data_out,
  input wire logic      serial_data_oe
);
  localparam int SPAN_LO = 510;
  localparam int SPAN_HI = 514;
  logic [11:0] span_q;
  logic [11:0] span_d;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Length of the current data enable stretch
  always_comb begin
    span_d = serial_data_oe ? span_q + 12'h001 : 12'h000;
  end
  always_ff @(posedge ref_clk) begin
    span_q <= rst ? 12'h000 : span_d;
  end
  ////////////////////////////////////////
  sequence s_cs_idle;
    spi_in.cs_n [*4];
  endsequence
  sequence s_oe_hold;
    serial_data_oe [*7];
  endsequence
  property p_oe_pair;
    output_frame_clock_oe == output_bit_clock_oe;
  endproperty
  property p_reset_slave;
    disable iff (1'b0) rst |=> !output_bit_clock_oe && !serial_data_oe;
  endproperty
  property p_data_on_fall;
    $changed(serial_data_out) && !output_bit_clock_oe |-> !$past(output_bit_clock_in);
  endproperty
  property p_oe_on_fall;
    $changed(serial_data_oe) && !output_bit_clock_oe |-> !$past(output_bit_clock_in);
  endproperty
  property p_subframe_span;
    $fell(serial_data_oe) |-> span_q inside {[SPAN_LO:SPAN_HI]};
  endproperty
  property p_oe_hold;
    $rose(serial_data_oe) |=> s_oe_hold;
  endproperty
  property p_miso_on_fall;
    $changed(spi_miso) && spi_miso_oe |-> !$past(spi_in.sclk);
  endproperty
  property p_miso_idle;
    s_cs_idle |-> !spi_miso_oe;
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("frame enable differs");
  a_reset_slave: assert property (p_reset_slave) else $error("not slave after reset");
  a_data_on_fall: assert property (p_data_on_fall) else $error("data moved off fall");
  a_oe_on_fall: assert property (p_oe_on_fall) else $error("enable moved off fall");
  a_subframe_span: assert property (p_subframe_span) else $error("bad sub-frame span");
  a_oe_hold: assert property (p_oe_hold) else $error("enable shorter than a bit");
  a_miso_on_fall: assert property (p_miso_on_fall) else $error("read bit moved off fall");
  a_miso_idle: assert property (p_miso_idle) else $error("read line driven when idle");
endmodule

// *** audio_sink_model.sv ***
`timescale 1ns/10ps
module audio_sink_model (
  input  wire logic    ref_clk,
  input  wire logic    run,
  input  wire logic    tdm,
  input  wire logic    i2s,
  input  wire logic    data,
  input  wire logic    data_oe,
  output logic         bclk,
  output logic         lrclk,
  output logic         busy,
  output logic [31:0]  nfr,
  output logic [127:0] cap_d,
  output logic [127:0] cap_oe
);
  int len;
  int idx;
  initial begin
    bclk = 1'b0;
    lrclk = 1'b0;
    busy = 1'b0;
    nfr = 32'h0;
    cap_d = '0;
    cap_oe = '0;
    forever begin
      @(posedge ref_clk);
      if (run) begin
        busy = 1'b1;
        #5;
        len = tdm ? 128 : 64;
        for (int p = 0; p < len; p++) begin
          bclk = 1'b1;
          #80;
          bclk = 1'b0;
          lrclk = i2s ? (p >= len / 2) : (tdm ? (p == 0) : (p < len / 2));
          idx = 127 - ((p + len - 1) % len);
          cap_d[idx] = data;
          cap_oe[idx] = data_oe;
          if (p == 0) nfr = nfr + 1;
          #80;
        end
        busy = 1'b0;
      end
    end
  end
endmodule

// *** tb_asrc_output_port.sv ***
`timescale 1ns/10ps
module tb_asrc_output_port;
  import asrc_out_pkg::*;
  logic         ref_clk;
  logic         rst;
  logic         rck;
  logic         stb;
  logic         run;
  logic         tdm;
  logic         i2s;
  logic         busy;
  logic         miso;
  logic         bck;
  logic         pbck;
  logic         bck_o;
  logic         bck_oe;
  logic         lrck;
  logic         plr;
  logic         lr_o;
  logic         lr_oe;
  logic         sd;
  logic         sd_oe;
  logic [31:0]  nfr;
  logic [127:0] cap_d;
  logic [127:0] cap_oe;
  spi_pins_t    spi;
  audio_pair_t  smp;
  ratio_t       ratio;
  int           n_fail;
  int           cmp_count;
  assign bck = bck_oe ? bck_o : pbck;
  assign lrck = lr_oe ? lr_o : plr;
  asrc_output_port asrc_output_port_i (
    .ref_clk(ref_clk), .rst(rst), .spi_in(spi), .spi_miso(miso), .spi_miso_oe(),
    .reference_clock_input(rck), .output_bit_clock_in(bck), .output_bit_clock_out(bck_o),
    .output_bit_clock_oe(bck_oe), .output_frame_clock_in(lrck), .output_frame_clock_out(lr_o),
    .output_frame_clock_oe(lr_oe), .serial_data_out(sd), .serial_data_oe(sd_oe),
    .sample_in(smp), .sample_strobe(stb), .ratio_in(ratio), .tdm_section_index(2'h1)
  );
  audio_sink_model audio_sink_model_i (
    .ref_clk(ref_clk), .run(run), .tdm(tdm), .i2s(i2s), .data(sd), .data_oe(sd_oe),
    .bclk(pbck), .lrclk(plr), .busy(busy), .nfr(nfr), .cap_d(cap_d), .cap_oe(cap_oe)
  );
  ////////////////////////////////////////
  task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic spi_xfer(input logic [15:0] f, output logic [7:0] r);
    r = 8'h00;
    spi.cs_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    for (int i = 15; i >= 0; i--) begin
      spi.mosi <= f[i];
      spi.sclk <= 1'b0;
      repeat (6) @(posedge ref_clk);
      if (i < 8) r = {r[6:0], miso};
      spi.sclk <= 1'b1;
      repeat (6) @(posedge ref_clk);
    end
    spi.sclk <= 1'b0;
    repeat (6) @(posedge ref_clk);
    spi.cs_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    spi_xfer({1'b0, a, d}, r);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] r);
    spi_xfer({1'b1, a, 8'h00}, r);
  endtask
  task automatic do_reset;
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic run_frames;
    logic [31:0] s;
    int          n;
    s = nfr;
    n = 0;
    run <= 1'b1;
    stb <= 1'b1;
    @(posedge ref_clk);
    stb <= 1'b0;
    while (nfr - s < 3 && n < 6000) begin
      @(posedge ref_clk);
      n++;
    end
    run <= 1'b0;
    @(posedge ref_clk);
    while (busy) @(posedge ref_clk);
    chk_word("frame_count", 32'h3, nfr - s);
  endtask
  function automatic logic [31:0] fmt_slot(input int k, input logic [23:0] w);
    case (k)
      1: return {1'b0, w, 7'h00};
      3: return {8'h00, w};
      default: return {w, 8'h00};
    endcase
  endfunction
  ////////////////////////////////////////
  task automatic t_regs;
    logic [7:0] r;
    rd(7'h04, r);
    chk_reg("left_att_rst", 8'h00, r);
    rd(7'h05, r);
    chk_reg("right_att_rst", 8'h00, r);
    rd(7'h03, r);
    chk_reg("format_rst", 8'h00, r);
    wr(7'h03, 8'hff);
    rd(7'h03, r);
    chk_reg("format", 8'hf7, r);
    wr(7'h04, 8'ha5);
    rd(7'h04, r);
    chk_reg("left_att", 8'ha5, r);
    wr(7'h05, 8'h3c);
    rd(7'h05, r);
    chk_reg("right_att", 8'h3c, r);
    rd(7'h20, r);
    chk_reg("unmapped", 8'h00, r);
  endtask
  task automatic t_ratio;
    ratio_t     a;
    ratio_t     b;
    logic [7:0] r;
    a = 16'h9da7;
    b = 16'h2c31;
    ratio <= a;
    rd(7'h06, r);
    chk_reg("ratio_hi", {a.integer_part, a.fraction_part[10:8]}, r);
    ratio <= b;
    wr(7'h06, 8'h00);
    wr(7'h07, 8'h00);
    rd(7'h07, r);
    chk_reg("ratio_lo", a.fraction_part[7:0], r);
    rd(7'h06, r);
    chk_reg("ratio_hi", {b.integer_part, b.fraction_part[10:8]}, r);
    rd(7'h07, r);
    chk_reg("ratio_lo", b.fraction_part[7:0], r);
  endtask
  task automatic t_formats;
    logic [1:0]  wl [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
    int          ln [4] = '{18, 20, 16, 24};
    logic [23:0] m;
    int          o;
    for (int k = 0; k < 4; k++) begin
      do_reset;
      wr(7'h03, {wl[k], k[1:0], 4'h0});
      tdm <= (k == 2);
      i2s <= (k == 1);
      smp <= {24'hc3a5f1, 24'h3c5a1e};
      run_frames;
      m = 24'hffffff << (24 - ln[k]);
      o = (k == 2) ? 0 : 64;
      chk_word("left_slot", fmt_slot(k, 24'hc3a5f1 & m), cap_d[o+32 +: 32]);
      chk_word("right_slot", fmt_slot(k, 24'h3c5a1e & m), cap_d[o +: 32]);
      if (k == 2) begin
        chk_word("foreign_oe", 32'h0, cap_oe[127:96] | cap_oe[95:64]);
        chk_word("own_oe", 32'hffffffff, cap_oe[63:32] & cap_oe[31:0]);
      end
    end
  endtask
  task automatic t_atten;
    do_reset;
    wr(7'h04, 8'h0c);
    wr(7'h05, 8'h18);
    smp <= {24'h400000, 24'h200000};
    run_frames;
    chk_word("left_att_out", {24'h200000, 8'h00}, cap_d[127:96]);
    chk_word("right_att_out", {24'h080000, 8'h00}, cap_d[95:64]);
    wr(7'h01, 8'h40);
    run_frames;
    chk_word("right_track_out", {24'h100000, 8'h00}, cap_d[95:64]);
  endtask
  task automatic gap(input logic lr, input int lim, output int c);
    logic p;
    repeat (2) begin
      c = 0;
      do begin
        p = lr ? lr_o : bck_o;
        @(posedge ref_clk);
        c++;
      end while (!((lr ? lr_o : bck_o) === 1'b1 && p === 1'b0) && c < lim);
    end
  endtask
  task automatic t_master;
    logic [2:0] md [4] = '{3'h1, 3'h2, 3'h3, 3'h3};
    int         ep [4] = '{16, 64, 32, 8};
    int         fp [4] = '{1024, 4096, 2048, 2048};
    int         c;
    for (int k = 0; k < 4; k++) begin
      do_reset;
      wr(7'h03, (k == 3) ? 8'h20 : 8'h00);
      wr(7'h01, {5'h00, md[k]});
      gap(1'b0, 300, c);
      chk_word("bclk_period", ep[k], c);
      gap(1'b1, 5000, c);
      chk_word("frame_period", fp[k], c);
      chk_reg("bclk_oe", 8'h01, {7'h00, bck_oe});
    end
  endtask
  ////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    rck = 1'b0;
    #7;
    forever #80 rck = ~rck;
  end
  initial begin
    repeat (80000) @(posedge ref_clk);
    n_fail++;
    summarize;
  end
  initial begin
    n_fail = 0;
    cmp_count = 0;
    rst = 1'b1;
    spi = 3'b100;
    smp = '0;
    stb = 1'b0;
    ratio = '0;
    run = 1'b0;
    tdm = 1'b0;
    i2s = 1'b0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_regs;
    t_ratio;
    t_formats;
    t_atten;
    t_master;
    summarize;
  end
endmodule
bind asrc_output_port asrc_output_port_checker asrc_output_port_checker_i (
  .ref_clk(ref_clk), .rst(rst), .spi_in(spi_in), .spi_miso(spi_miso),
  .spi_miso_oe(spi_miso_oe), .output_bit_clock_in(output_bit_clock_in),
  .output_bit_clock_oe(output_bit_clock_oe), .output_frame_clock_oe(output_frame_clock_oe),
  .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe)
);
